/* flash_sec_pkg.sv */
// constants, events and enumerations shared by the security command unit
package flash_sec_pkg;

  localparam logic [7:0] OP_LOCK_LEAD   = 8'h3D;
  localparam logic [7:0] OP_FREEZE_LEAD = 8'h34;
  localparam logic [7:0] OP_OTP_PROG    = 8'h9B;
  localparam logic [7:0] OP_READ_MAP    = 8'h35;
  localparam logic [7:0] OP_READ_SEC    = 8'h77;
  localparam logic [7:0] OP_STATUS      = 8'hD7;

  localparam logic [7:0] LOCK_SEQ_1     = 8'h2A;
  localparam logic [7:0] LOCK_SEQ_2     = 8'h7F;
  localparam logic [7:0] LOCK_SEQ_3     = 8'h30;
  localparam logic [7:0] FREEZE_SEQ_1   = 8'h55;
  localparam logic [7:0] FREEZE_SEQ_2   = 8'hAA;
  localparam logic [7:0] FREEZE_SEQ_3   = 8'h40;
  localparam logic [7:0] PROG_SEQ_N     = 8'h00;

  localparam logic [7:0] MAP_LOCKED     = 8'hFF;
  localparam logic [7:0] MAP_UNLOCKED   = 8'h00;
  localparam logic [7:0] UNDEF_BYTE     = 8'h00;
  localparam logic [7:0] USER_ERASED    = 8'hFF;

  localparam int         ADDR_W         = 24;
  localparam int         SECTOR_LSB     = 16;
  localparam int         SECTOR_W       = 6;
  localparam int         SUB_LSB        = 12;
  localparam int         SUB_W          = 4;
  localparam int         STAT_RDY_BIT   = 7;
  localparam int         STAT_LE_BIT    = 0;
  localparam logic [1:0] HDR_LAST       = 2'd2;
  localparam logic [2:0] BIT_LAST       = 3'd7;
  localparam logic [7:0] IDX_SAT        = 8'hFF;
  localparam int         CLK_PERIOD_NS  = 8;

  typedef struct packed {
    logic cs_active;
    logic cs_end;
    logic sck_rise;
    logic sck_fall;
    logic si;
  } link_ev_s;

  typedef enum logic [2:0] {
    cmd_none, cmd_lock, cmd_freeze, cmd_prog, cmd_map, cmd_sec, cmd_stat
  } cmd_e;

  typedef enum logic [2:0] {
    st_idle, st_seq, st_addr, st_armed, st_prog, st_dummy, st_out, st_ignore
  } link_st_e;

  typedef enum logic [1:0] {
    op_none, op_lock, op_freeze, op_prog
  } op_e;

endpackage

/* serial_link_front.sv */
// pin synchronisers and serial clock edge finder
`timescale 1ns/1ps
`default_nettype none
module serial_link_front
  import flash_sec_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic cs_n_pin,
  input  wire logic sck_pin,
  input  wire logic si_pin,
  output link_ev_s  ev
);

  logic [2:0] cs_sync_reg;
  logic [2:0] sck_sync_reg;
  logic [1:0] si_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cs_sync_reg  <= 3'b111;
      sck_sync_reg <= 3'b000;
      si_sync_reg  <= 2'b00;
    end else begin
      cs_sync_reg  <= {cs_sync_reg[1:0], cs_n_pin};
      sck_sync_reg <= {sck_sync_reg[1:0], sck_pin};
      si_sync_reg  <= {si_sync_reg[0], si_pin};
    end
  end

  // stage 0 feeds only stage 1
  always_comb begin
    ev.cs_active = ~cs_sync_reg[1];
    ev.cs_end    = cs_sync_reg[1] & ~cs_sync_reg[2];
    ev.sck_rise  = ~cs_sync_reg[1] & sck_sync_reg[1] & ~sck_sync_reg[2];
    ev.sck_fall  = ~cs_sync_reg[1] & ~sck_sync_reg[1] & sck_sync_reg[2];
    ev.si        = si_sync_reg[1];
  end

endmodule
`default_nettype wire

/* flash_security_command_unit.sv */
// security command unit: lockdown, freeze, lockdown map and security register
`timescale 1ns/1ps
`default_nettype none
module flash_security_command_unit
  import flash_sec_pkg::*;
#(
  parameter int         PROG_TIME_NS   = 3000,
  parameter int         FREEZE_TIME_NS = 1000,
  parameter int         SECTORS        = 64,
  parameter int         USER_BYTES     = 64,
  // factory value seed, arbitrary
  parameter logic [7:0] FACTORY_SEED   = 8'h5A
)
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              cs_n_pin,
  input  wire logic              sck_pin,
  input  wire logic              si_pin,
  output logic                   so_out,
  output logic                   so_oe_n,
  input  wire logic [ADDR_W-1:0] array_addr,
  output logic                   array_write_allowed,
  output logic                   ready_flag,
  output logic                   lockdown_enable_flag,
  output logic                   buf1_we,
  output logic [5:0]             buf1_addr,
  output logic [7:0]             buf1_data
);

  localparam int PROG_CYCLES_RAW   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int FREEZE_CYCLES_RAW = FREEZE_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_CYCLES       = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;
  localparam int FREEZE_CYCLES     = (FREEZE_CYCLES_RAW < 1) ? 1 : FREEZE_CYCLES_RAW;
  localparam logic [15:0] PROG_CNT   = 16'(PROG_CYCLES - 1);
  localparam logic [15:0] FREEZE_CNT = 16'(FREEZE_CYCLES - 1);

  if (SECTORS != 64 || USER_BYTES != 64 || PROG_CYCLES > 65536 ||
      FREEZE_CYCLES > 65536) begin : g_bad_params
    $error("unsupported parameter values");
  end

  link_ev_s ev;

  serial_link_front u_front (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .cs_n_pin (cs_n_pin),
    .sck_pin  (sck_pin),
    .si_pin   (si_pin),
    .ev       (ev)
  );

  logic [2:0]        bit_cnt_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        shift_next;
  logic              byte_done;
  link_st_e          state_reg;
  cmd_e              cmd_reg;
  logic [1:0]        hdr_cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [5:0]        prog_ptr_reg;
  logic              prog_any_reg;
  logic [7:0]        stage_reg [USER_BYTES];
  logic [7:0]        user_reg [USER_BYTES];
  logic              otp_used_reg;
  logic [63:1]       locked_reg;
  logic [1:0]        sub_lock_reg;
  logic              lock_en_reg;
  op_e               op_reg;
  logic [15:0]       busy_cnt_reg;
  logic              busy;
  logic [7:0]        out_idx_reg;
  logic [2:0]        obit_reg;
  logic [7:0]        cur_byte;
  logic [7:0]        stat_byte;

  // serial input, msb first on rising clock
  assign shift_next = {shift_reg[6:0], ev.si};
  assign byte_done  = ev.sck_rise && (bit_cnt_reg == BIT_LAST);
  assign busy       = (op_reg != op_none);

  function automatic logic [7:0] seq_byte(input cmd_e c, input logic [1:0] n);
    logic [7:0] b;
    b = PROG_SEQ_N;
    case (c)
      cmd_lock:   b = (n == 2'd0) ? LOCK_SEQ_1 : (n == 2'd1) ? LOCK_SEQ_2 : LOCK_SEQ_3;
      cmd_freeze: b = (n == 2'd0) ? FREEZE_SEQ_1 : (n == 2'd1) ? FREEZE_SEQ_2 : FREEZE_SEQ_3;
      default:    b = PROG_SEQ_N;
    endcase
    return b;
  endfunction

  function automatic logic [7:0] map_byte(input logic [5:0] idx, input logic [63:1] lk,
                                          input logic [1:0] sub);
    logic [7:0] b;
    b = MAP_UNLOCKED;
    if (idx == 6'd0) begin
      b = {{2{sub[0]}}, {2{sub[1]}}, 4'h0};
    end else begin
      b = lk[idx] ? MAP_LOCKED : MAP_UNLOCKED;
    end
    return b;
  endfunction

  function automatic logic is_locked(input logic [ADDR_W-1:0] a, input logic [63:1] lk,
                                     input logic [1:0] sub);
    logic [SECTOR_W-1:0] s;
    s = a[SECTOR_LSB +: SECTOR_W];
    if (s == '0) begin
      return (a[SUB_LSB +: SUB_W] == '0) ? sub[0] : sub[1];
    end
    return lk[s];
  endfunction

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
    end else if (!ev.cs_active) begin
      bit_cnt_reg <= '0;
    end else if (ev.sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
      shift_reg   <= shift_next;
    end
  end

  // command decoder
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= st_idle;
      cmd_reg   <= cmd_none;
    end else if (!ev.cs_active) begin
      state_reg <= st_idle;
    end else if (byte_done) begin
      case (state_reg)
        st_idle: begin
          if (shift_next == OP_STATUS) begin
            state_reg <= st_out;
            cmd_reg   <= cmd_stat;
          end else if (busy) begin
            state_reg <= st_ignore;
          end else if (shift_next == OP_READ_MAP) begin
            state_reg <= st_dummy;
            cmd_reg   <= cmd_map;
          end else if (shift_next == OP_READ_SEC) begin
            state_reg <= st_dummy;
            cmd_reg   <= cmd_sec;
          end else if (shift_next == OP_LOCK_LEAD) begin
            state_reg <= st_seq;
            cmd_reg   <= cmd_lock;
          end else if (shift_next == OP_FREEZE_LEAD) begin
            state_reg <= st_seq;
            cmd_reg   <= cmd_freeze;
          end else if (shift_next == OP_OTP_PROG) begin
            state_reg <= st_seq;
            cmd_reg   <= cmd_prog;
          end else begin
            state_reg <= st_ignore;
          end
        end
        st_seq: begin
          if (shift_next != seq_byte(cmd_reg, hdr_cnt_reg)) begin
            state_reg <= st_ignore;
          end else if (hdr_cnt_reg == HDR_LAST) begin
            case (cmd_reg)
              cmd_lock:   state_reg <= st_addr;
              cmd_freeze: state_reg <= st_armed;
              default:    state_reg <= st_prog;
            endcase
          end
        end
        st_addr: begin
          if (hdr_cnt_reg == HDR_LAST) begin
            state_reg <= st_armed;
          end
        end
        st_armed: begin
          // freeze drops extra bytes, lockdown with extra bytes is void
          if (cmd_reg == cmd_lock) begin
            state_reg <= st_ignore;
          end
        end
        st_dummy: begin
          if (hdr_cnt_reg == HDR_LAST) begin
            state_reg <= st_out;
          end
        end
        st_prog, st_out, st_ignore: state_reg <= state_reg;
        default: state_reg <= st_ignore;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hdr_cnt_reg <= '0;
      addr_reg    <= '0;
    end else if (!ev.cs_active) begin
      hdr_cnt_reg <= '0;
    end else if (byte_done &&
                 (state_reg == st_seq || state_reg == st_addr || state_reg == st_dummy)) begin
      hdr_cnt_reg <= (hdr_cnt_reg == HDR_LAST) ? 2'd0 : hdr_cnt_reg + 2'd1;
      if (state_reg == st_addr) begin
        addr_reg <= {addr_reg[ADDR_W-9:0], shift_next};
      end
    end
  end

  // user data capture through data buffer one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prog_ptr_reg <= '0;
      prog_any_reg <= 1'b0;
      buf1_we      <= 1'b0;
      buf1_addr    <= '0;
      buf1_data    <= '0;
    end else begin
      buf1_we <= 1'b0;
      if (!ev.cs_active) begin
        prog_ptr_reg <= '0;
        if (ev.cs_end) begin
          prog_any_reg <= 1'b0;
        end
      end else if (byte_done && state_reg == st_prog) begin
        buf1_we      <= 1'b1;
        buf1_addr    <= prog_ptr_reg;
        buf1_data    <= shift_next;
        prog_ptr_reg <= prog_ptr_reg + 6'd1;
        prog_any_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (ev.cs_active && byte_done && state_reg == st_prog) begin
      stage_reg[prog_ptr_reg] <= shift_next;
    end
  end

  // self-timed operations
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_reg       <= op_none;
      busy_cnt_reg <= '0;
    end else if (busy) begin
      if (busy_cnt_reg == '0) begin
        op_reg <= op_none;
      end else begin
        busy_cnt_reg <= busy_cnt_reg - 16'd1;
      end
    end else if (ev.cs_end) begin
      if (state_reg == st_armed && cmd_reg == cmd_lock && lock_en_reg) begin
        op_reg       <= op_lock;
        busy_cnt_reg <= PROG_CNT;
      end else if (state_reg == st_armed && cmd_reg == cmd_freeze) begin
        op_reg       <= op_freeze;
        busy_cnt_reg <= FREEZE_CNT;
      end else if (state_reg == st_prog && prog_any_reg && !otp_used_reg) begin
        op_reg       <= op_prog;
        busy_cnt_reg <= PROG_CNT;
      end
    end
  end

  // nonvolatile state commits at the end of an operation
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      locked_reg   <= '0;
      sub_lock_reg <= '0;
      lock_en_reg  <= 1'b1;
    end else if (busy && busy_cnt_reg == '0) begin
      if (op_reg == op_lock) begin
        if (addr_reg[SECTOR_LSB +: SECTOR_W] == '0) begin
          if (addr_reg[SUB_LSB +: SUB_W] == '0) begin
            sub_lock_reg[0] <= 1'b1;
          end else begin
            sub_lock_reg[1] <= 1'b1;
          end
        end else begin
          locked_reg[addr_reg[SECTOR_LSB +: SECTOR_W]] <= 1'b1;
        end
      end else if (op_reg == op_freeze) begin
        lock_en_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      otp_used_reg <= 1'b0;
      for (int i = 0; i < USER_BYTES; i++) begin
        user_reg[i] <= USER_ERASED;
      end
    end else if (busy && busy_cnt_reg == '0 && op_reg == op_prog) begin
      otp_used_reg <= 1'b1;
      for (int i = 0; i < USER_BYTES; i++) begin
        user_reg[i] <= stage_reg[i];
      end
    end
  end

  // serial output
  always_comb begin
    stat_byte               = '0;
    stat_byte[STAT_RDY_BIT] = ~busy;
    cur_byte                = UNDEF_BYTE;
    case (cmd_reg)
      cmd_map: begin
        if (out_idx_reg < 8'(SECTORS)) begin
          cur_byte = map_byte(out_idx_reg[5:0], locked_reg, sub_lock_reg);
        end
      end
      cmd_sec: begin
        if (out_idx_reg < 8'(USER_BYTES)) begin
          cur_byte = user_reg[out_idx_reg[5:0]];
        end else if (out_idx_reg < 8'(2 * USER_BYTES)) begin
          cur_byte = FACTORY_SEED ^ {2'b00, out_idx_reg[5:0]};
        end
      end
      cmd_stat: begin
        cur_byte = stat_byte;
        if (out_idx_reg[0]) begin
          cur_byte[STAT_LE_BIT] = lock_en_reg;
        end
      end
      default: cur_byte = UNDEF_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_idx_reg <= '0;
      obit_reg    <= BIT_LAST;
      so_out      <= 1'b0;
      so_oe_n     <= 1'b1;
    end else begin
      so_oe_n <= ~(ev.cs_active && state_reg == st_out);
      if (!ev.cs_active) begin
        out_idx_reg <= '0;
        obit_reg    <= BIT_LAST;
      end else if (ev.sck_fall && state_reg == st_out) begin
        so_out   <= cur_byte[obit_reg];
        obit_reg <= obit_reg - 3'd1;
        if (obit_reg == '0 && out_idx_reg != IDX_SAT) begin
          out_idx_reg <= out_idx_reg + 8'd1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      array_write_allowed  <= 1'b1;
      ready_flag           <= 1'b1;
      lockdown_enable_flag <= 1'b1;
    end else begin
      array_write_allowed  <= ~is_locked(array_addr, locked_reg, sub_lock_reg);
      ready_flag           <= ~busy;
      lockdown_enable_flag <= lock_en_reg;
    end
  end

endmodule
`default_nettype wire

/* flash_sec_checker.sv */
// port checks for the security command unit
`timescale 1ns/1ps
`default_nettype none
module flash_sec_checker
  import flash_sec_pkg::*;
#(
  parameter int PROG_TIME_NS = 3000
)
(
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              cs_n_pin,
  input wire logic              so_oe_n,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic              array_write_allowed,
  input wire logic              ready_flag,
  input wire logic              lockdown_enable_flag,
  input wire logic              buf1_we
);
  localparam int BUSY_MAX = PROG_TIME_NS / CLK_PERIOD_NS;
  logic [15:0] busy_cnt_reg;

  // length of the current busy stretch
  always_ff @(posedge clk_sys) begin
    if (reset || ready_flag) begin
      busy_cnt_reg <= 16'h0000;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 16'h0001;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_reset_quiet: assert property (disable iff (1'b0)
    reset |=> so_oe_n && ready_flag && lockdown_enable_flag && !buf1_we)
    else $error("outputs not quiet after reset");
  a_deselect_float: assert property (
    $rose(cs_n_pin) |-> ##[1:6] so_oe_n) else $error("output not released");
  a_idle_float: assert property (
    cs_n_pin [*6] |-> so_oe_n) else $error("output driven while deselected");
  a_freeze_sticky: assert property (
    !lockdown_enable_flag |=> !lockdown_enable_flag) else $error("freeze undone");
  a_lock_sticky: assert property (
    $stable(array_addr) && !array_write_allowed |=> !array_write_allowed)
    else $error("locked sector became writable");
  a_busy_deselected: assert property (
    $fell(ready_flag) |-> cs_n_pin && $past(cs_n_pin, 3))
    else $error("busy started inside a frame");
  a_busy_min: assert property (
    $fell(ready_flag) |=> !ready_flag [*3]) else $error("busy too short");
  a_busy_bounded: assert property (
    busy_cnt_reg <= BUSY_MAX) else $error("busy too long");
  a_buf_pulse: assert property (
    buf1_we |-> !$past(cs_n_pin, 2) ##1 !buf1_we) else $error("bad buffer write");

  c_busy: cover property ($fell(ready_flag));
  c_freeze: cover property ($fell(lockdown_enable_flag));
  c_buf: cover property (buf1_we);
endmodule

bind flash_security_command_unit flash_sec_checker #(
  .PROG_TIME_NS(PROG_TIME_NS)
) i_flash_sec_checker (.clk_sys, .reset, .cs_n_pin, .so_oe_n, .array_addr,
  .array_write_allowed, .ready_flag, .lockdown_enable_flag, .buf1_we);
`default_nettype wire

/* host_model.sv */
// host side serial model: select, clock and data in
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk_sys,
  input  wire logic so_out,
  input  wire logic so_oe_n,
  output var logic  cs_n_pin,
  output var logic  sck_pin,
  output var logic  si_pin
);
  initial begin
    cs_n_pin = 1'b1;
    sck_pin  = 1'b0;
    si_pin   = 1'b0;
  end

  task automatic open_f();
    cs_n_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // msb first, data set while clock low, read while high
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_pin <= tx[i];
      repeat (4) @(posedge clk_sys);
      sck_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rx[i] = so_oe_n ? 1'bx : so_out;
      sck_pin <= 1'b0;
    end
  endtask

  // released data line toggles, clock stays low
  task automatic close_f();
    repeat (4) @(posedge clk_sys);
    cs_n_pin <= 1'b1;
    si_pin   <= ~si_pin;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the security command unit
`timescale 1ns/1ps
`default_nettype none
module tb
  import flash_sec_pkg::*;
;
  logic              clk_sys;
  logic              reset;
  logic              cs_n_pin;
  logic              sck_pin;
  logic              si_pin;
  logic              so_out;
  logic              so_oe_n;
  logic [ADDR_W-1:0] array_addr;
  logic              array_write_allowed;
  logic              ready_flag;
  logic              lockdown_enable_flag;
  logic              buf1_we;
  logic [5:0]        buf1_addr;
  logic [7:0]        buf1_data;
  logic [7:0]        got [0:127];
  logic [7:0]        q [$];
  int                num_errors;
  int                compares;
  int                wr_cnt;
  logic [5:0]        wr_addr;
  logic [7:0]        wr_data;

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  flash_security_command_unit #(
    .PROG_TIME_NS  (6000),
    .FREEZE_TIME_NS(40),
    .FACTORY_SEED  (8'h3C) // arbitrary
  ) i_flash_security_command_unit (.clk_sys, .reset, .cs_n_pin, .sck_pin, .si_pin,
    .so_out, .so_oe_n, .array_addr, .array_write_allowed, .ready_flag,
    .lockdown_enable_flag, .buf1_we, .buf1_addr, .buf1_data);

  host_model i_host_model (.clk_sys, .so_out, .so_oe_n, .cs_n_pin, .sck_pin, .si_pin);

  always @(posedge clk_sys) begin
    if (buf1_we === 1'b1) begin
      wr_cnt  <= wr_cnt + 1;
      wr_addr <= buf1_addr;
      wr_data <= buf1_data;
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one frame: bytes of q, then nrd bytes read back
  task automatic send(input int nrd);
    logic [7:0] r;
    i_host_model.open_f();
    foreach (q[i]) i_host_model.xb(q[i], r);
    for (int i = 0; i < nrd; i++) i_host_model.xb(8'h00, got[i]);
    i_host_model.close_f();
  endtask

  task automatic wait_rdy();
    int n = 0;
    while (ready_flag !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 3000) begin
      num_errors++;
      test_done();
    end
  endtask

  task automatic lock(input logic [23:0] a);
    q = '{8'h3D, 8'h2A, 8'h7F, 8'h30, a[23:16], a[15:8], a[7:0]};
    send(0);
  endtask

  task automatic rmap(input int n);
    q = '{8'h35, 8'h00, 8'h00, 8'h00};
    send(n);
  endtask

  task automatic t_reset();
    chk({7'h00, ready_flag}, 8'h01);
    chk({7'h00, lockdown_enable_flag}, 8'h01);
    chk({7'h00, so_oe_n}, 8'h01);
    rmap(64);
    for (int i = 0; i < 64; i++) begin
      chk(got[i], 8'h00);
    end
    $display("t_reset done");
  endtask

  task automatic t_lock();
    lock(24'h05_1234);
    q = '{8'hD7};
    send(2);
    chk(got[0], 8'h00);
    chk(got[1], 8'h01);
    wait_rdy();
    send(2);
    chk(got[0], 8'h80);
    chk(got[1], 8'h81);
    array_addr <= 24'h05_FFFF;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, array_write_allowed}, 8'h00);
    array_addr <= 24'h06_0000;
    repeat (3) @(posedge clk_sys);
    chk({7'h00, array_write_allowed}, 8'h01);
    q = '{8'h3D, 8'h2A, 8'h7F, 8'h31, 8'h07, 8'h00, 8'h00};
    send(0);
    chk({7'h00, ready_flag}, 8'h01);
    lock(24'h00_1000);
    wait_rdy();
    rmap(1);
    chk(got[0], 8'h30);
    lock(24'h00_0000);
    wait_rdy();
    rmap(64);
    for (int i = 0; i < 64; i++) begin
      chk(got[i], i == 0 ? 8'hF0 : i == 5 ? 8'hFF : 8'h00);
    end
    $display("t_lock done");
  endtask

  task automatic t_otp();
    q = '{8'h9B, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 65; i++) begin
      q.push_back(8'hA0 ^ 8'(i));
    end
    wr_cnt = 0;
    send(0);
    chk(8'(wr_cnt), 8'h41);
    chk({2'b00, wr_addr}, 8'h00);
    chk(wr_data, 8'hE0);
    chk({7'h00, ready_flag}, 8'h00);
    wait_rdy();
    q = '{8'h77, 8'h00, 8'h00, 8'h00};
    send(128);
    for (int i = 0; i < 128; i++) begin
      chk(got[i], i == 0 ? 8'hE0 : i < 64 ? 8'hA0 ^ 8'(i) : 8'h3C ^ 8'(i - 64));
    end
    q = '{8'h9B, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22};
    send(0);
    chk({7'h00, ready_flag}, 8'h01);
    q = '{8'h77, 8'h00, 8'h00, 8'h00};
    send(2);
    chk(got[0], 8'hE0);
    chk(got[1], 8'hA1);
    $display("t_otp done");
  endtask

  task automatic t_freeze();
    q = '{8'h34, 8'h55, 8'hAA, 8'h40, 8'h3D};
    send(0);
    wait_rdy();
    chk({7'h00, lockdown_enable_flag}, 8'h00);
    q = '{8'hD7};
    send(2);
    chk(got[1], 8'h80);
    lock(24'h09_0000);
    chk({7'h00, ready_flag}, 8'h01);
    rmap(10);
    chk(got[9], 8'h00);
    chk(got[5], 8'hFF);
    $display("t_freeze done");
  endtask

  initial begin
    reset = 1'b1;
    array_addr = 24'h00_0000;
    num_errors = 0;
    compares = 0;
    wr_cnt = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_lock();
    t_otp();
    t_freeze();
    test_done();
  end
endmodule
`default_nettype wire
